// ---- design/dicr_pkg.sv ----
// constants shared by the digital input channel router
package dicr_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam int WORD_W = 16;
    localparam int KEEP_W = 13;
    localparam int CUT_W = 3;
    localparam int BYTE_W = 8;
    localparam int QUAL_W = 8;
    localparam int RATE_W = 28;
    localparam int RATIO_W = 10;
    localparam int NCH = 2;

    // register byte offsets
    localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] REG_QUAL1 = 5'h04;
    localparam logic [ADDR_W-1:0] REG_QUAL2 = 5'h08;
    localparam logic [ADDR_W-1:0] REG_RATE = 5'h0C;
    localparam logic [ADDR_W-1:0] REG_RATIO = 5'h10;
    localparam logic [ADDR_W-1:0] REG_STATUS = 5'h14;
    localparam logic [ADDR_W-1:0] REG_SAMP1 = 5'h18;
    localparam logic [ADDR_W-1:0] REG_SAMP2 = 5'h1C;

    // control field positions; per-channel fields take two bits
    localparam int B_KIND = 0;
    localparam int B_SRC1 = 2;
    localparam int B_CH2_POD1 = 3;
    localparam int B_OFFSET = 4;
    localparam int B_BITS8 = 6;
    localparam int B_UPPER = 8;
    localparam int CTRL_W = 10;
    localparam logic [CTRL_W-1:0] CTRL_RST = 10'h300;

    // qualifier pattern fields
    localparam int Q_CARE_LSB = 0;
    localparam int Q_VAL_LSB = 8;
    localparam logic [2*QUAL_W-1:0] QUAL_RST = 16'h0000;

    // sample rate in millihertz, mixed ratio
    localparam logic [RATE_W-1:0] RATE_MIN = 28'h000_0001;
    localparam logic [RATE_W-1:0] RATE_MAX = 28'hF42_4000;
    localparam logic [RATIO_W-1:0] RATIO_MIN = 10'h001;
    localparam logic [RATIO_W-1:0] RATIO_MAX = 10'h200;

    localparam logic [WORD_W:0] ROUND_HALF = 17'h0_0004;
    localparam logic [KEEP_W-1:0] SAT_MAX = 13'h0FFF;

    // status bits
    localparam int S_SRC_ACT = 2;
    localparam int S_REFUSE = 3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- design/dicr_lane.sv ----
// link-side capture of one channel's pod word
`timescale 1ns/10ps
`default_nettype none
module dicr_lane #(
    parameter int WORD_W = 16,
    parameter int QUAL_W = 8
) (
    input wire logic link_clk,
    input wire logic rst_cd,
    input wire logic enable_cd,
    input wire logic pod_sel_cd,
    input wire logic [QUAL_W-1:0] care_cd,
    input wire logic [QUAL_W-1:0] value_cd,
    input wire logic [WORD_W-1:0] pod1,
    input wire logic [WORD_W-1:0] pod2,
    input wire logic [QUAL_W-1:0] qual,
    output logic [WORD_W-1:0] word,
    output logic toggle
);
    // settings are static while a record runs; three flops each
    localparam int SYN_W = 3 + 2*QUAL_W;
    logic [SYN_W-1:0] syn_in, syn1_r, syn2_r, syn3_r, held_r, agreed;
    logic rst_s, en_s, sel_s;
    logic [QUAL_W-1:0] care_s, val_s;
    logic [WORD_W-1:0] word_r, word_nxt;
    logic tog_r, tog_nxt;
    logic match;

    assign syn_in = {rst_cd, enable_cd, pod_sel_cd, care_cd, value_cd};

    always_ff @(posedge link_clk) begin
        syn1_r <= syn_in;
        syn2_r <= syn1_r;
        syn3_r <= syn2_r;
        held_r <= agreed;
    end

    // a bit moves once the second and third stage agree
    always_comb begin
        agreed = (syn2_r & syn3_r) | (held_r & (syn2_r ^ syn3_r));
    end

    assign {rst_s, en_s, sel_s, care_s, val_s} = agreed;

    always_comb begin
        match = ((qual ^ val_s) & care_s) == '0; // RULE12
        word_nxt = word_r;
        tog_nxt = tog_r;
        if (en_s && match) begin
            word_nxt = sel_s ? pod1 : pod2; // RULE12
            tog_nxt = ~tog_r;
        end
    end

    always_ff @(posedge link_clk) begin
        if (rst_s) begin
            word_r <= '0;
            tog_r <= 1'b0;
        end else begin
            word_r <= word_nxt;
            tog_r <= tog_nxt;
        end
    end

    assign word = word_r;
    assign toggle = tog_r;
endmodule
`default_nettype wire

// ---- design/dicr_top.sv ----
// two-channel digital input router with register slave
//
// Functional notes
// RULE1: a sample rate of 0.001 Hz to 256 kHz is held and scales time.
// RULE2: each channel has an analog/digital kind, analog at reset.
// RULE3: routing channel 1 to the source forces the source kind digital (here only while channel 1 is also set digital).
// RULE4: the source route is refused while the mixed ratio is above 1.
// RULE5: from the source, channel 1 takes 16-bit words at source alignment.
// RULE6: channel 1 takes pod 1 words by default.
// RULE7: channel 2 takes pod 2 by default or pod 1, shared freely.
// RULE8: words read as twos complement by default, else offset binary.
// RULE9: channel 1 format cannot be set while routed to the source.
// RULE10: channel 2 has the same settings as channel 1 minus the source.
// RULE11: 16-bit words keep upper 13 bits rounded or lower 13 bits.
// RULE12: a word latches on the data-clock edge when qualifiers match.
// RULE13: offset binary is made signed by inverting the top used bit.
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module dicr_top
    import dicr_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [dicr_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [dicr_pkg::DATA_W-1:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [dicr_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [dicr_pkg::DATA_W-1:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic LINK_CLK,
    input wire logic [dicr_pkg::WORD_W-1:0] POD1_DATA,
    input wire logic [dicr_pkg::WORD_W-1:0] POD2_DATA,
    input wire logic [dicr_pkg::QUAL_W-1:0] QUALIFIER,
    input wire logic [dicr_pkg::WORD_W-1:0] SRC_WORD,
    input wire logic SRC_VALID,
    input wire logic SRC_UPPER_ALIGN,
    input wire logic SRC_OFFSET_BINARY,
    output logic SRC_KIND_DIGITAL,
    output logic [dicr_pkg::WORD_W-1:0] SAMPLE1,
    output logic [dicr_pkg::WORD_W-1:0] SAMPLE2,
    output logic [1:0] SAMPLE_VALID,
    output logic [dicr_pkg::RATE_W-1:0] SAMPLE_RATE_SETTING
);
    import dicr_pkg::*;

    default clocking dc @(posedge CLK); endclocking
    default disable iff (RESET);

    // format a raw word into a signed sample
    function automatic logic [WORD_W-1:0] shape(
        input logic [WORD_W-1:0] w, input logic offset,
        input logic bits8, input logic upper);
        logic [WORD_W-1:0] x;
        logic [WORD_W:0] s;
        logic [KEEP_W:0] r;
        x = w;
        s = '0;
        r = '0;
        if (bits8) begin
            if (offset) x[BYTE_W-1] = ~x[BYTE_W-1]; // RULE13
            shape = {{BYTE_W{x[BYTE_W-1]}}, x[BYTE_W-1:0]};
        end else if (upper) begin
            if (offset) x[WORD_W-1] = ~x[WORD_W-1]; // RULE13
            s = {x[WORD_W-1], x} + ROUND_HALF; // RULE11
            r = s[WORD_W:CUT_W];
            if (!r[KEEP_W] && r[KEEP_W-1]) r = {1'b0, SAT_MAX};
            shape = {{CUT_W{r[KEEP_W-1]}}, r[KEEP_W-1:0]};
        end else begin
            if (offset) x[KEEP_W-1] = ~x[KEEP_W-1]; // RULE13
            shape = {{CUT_W{x[KEEP_W-1]}}, x[KEEP_W-1:0]}; // RULE11
        end
    endfunction

    function automatic logic [DATA_W-1:0] merge(
        input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] d,
        input logic [3:0] strb);
        merge = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) merge[b*BYTE_W +: BYTE_W] = d[b*BYTE_W +: BYTE_W];
        end
    endfunction

    // bus slave state
    logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
    logic [ADDR_W-1:0] waddr_r, waddr_nxt;
    logic [DATA_W-1:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic wr_en, wr_hit;

    // configuration state
    logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
    logic [2*QUAL_W-1:0] qual_r [NCH];
    logic [2*QUAL_W-1:0] qual_nxt [NCH];
    logic [RATE_W-1:0] rate_r, rate_nxt;
    logic [RATIO_W-1:0] ratio_r, ratio_nxt;
    logic refuse_r, refuse_nxt;
    logic [DATA_W-1:0] merged, rd_mux;
    logic refuse_now, src_act;
    logic [WORD_W-1:0] samp_q [NCH];
    logic [NCH-1:0] sval_q;

    assign S_AXI_AWREADY = !aw_full_r && !bvalid_r;
    assign S_AXI_WREADY = !w_full_r && !bvalid_r;
    assign S_AXI_ARREADY = !rvalid_r;
    assign S_AXI_BVALID = bvalid_r;
    assign S_AXI_BRESP = bresp_r;
    assign S_AXI_RVALID = rvalid_r;
    assign S_AXI_RRESP = rresp_r;
    assign S_AXI_RDATA = rdata_r;
    assign wr_en = aw_full_r && w_full_r;
    assign wr_hit = waddr_r <= REG_RATIO && waddr_r[1:0] == 2'h0;

    always_comb begin
        rd_mux = '0;
        case (S_AXI_ARADDR)
            REG_CTRL: rd_mux = DATA_W'(ctrl_r);
            REG_QUAL1: rd_mux = DATA_W'(qual_r[0]);
            REG_QUAL2: rd_mux = DATA_W'(qual_r[1]);
            REG_RATE: rd_mux = DATA_W'(rate_r);
            REG_RATIO: rd_mux = DATA_W'(ratio_r);
            REG_STATUS: rd_mux = DATA_W'({refuse_r, src_act,
                ctrl_r[B_KIND +: NCH]});
            REG_SAMP1: rd_mux = DATA_W'(samp_q[0]);
            REG_SAMP2: rd_mux = DATA_W'(samp_q[1]);
            default: rd_mux = '0;
        endcase
    end

    always_comb begin
        aw_full_nxt = aw_full_r;
        w_full_nxt = w_full_r;
        waddr_nxt = waddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_full_nxt = 1'b1;
            waddr_nxt = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_full_nxt = 1'b1;
            wdata_nxt = S_AXI_WDATA;
            wstrb_nxt = S_AXI_WSTRB;
        end
        if (wr_en) begin
            aw_full_nxt = 1'b0;
            w_full_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_r && S_AXI_BREADY) begin
            bvalid_nxt = 1'b0;
        end
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rvalid_nxt = 1'b1;
            rdata_nxt = rd_mux;
            rresp_nxt = (S_AXI_ARADDR[1:0] == 2'h0) ? RESP_OKAY
                : RESP_SLVERR;
        end else if (rvalid_r && S_AXI_RREADY) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            waddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= '0;
        end else begin
            aw_full_r <= aw_full_nxt;
            w_full_r <= w_full_nxt;
            waddr_r <= waddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // configuration writes
    always_comb begin
        ctrl_nxt = ctrl_r;
        qual_nxt = qual_r;
        rate_nxt = rate_r;
        ratio_nxt = ratio_r;
        refuse_nxt = refuse_r;
        merged = '0;
        if (wr_en) begin
            case (waddr_r)
                REG_CTRL: begin
                    merged = merge(DATA_W'(ctrl_r), wdata_r, wstrb_r);
                    ctrl_nxt = merged[CTRL_W-1:0];
                    if (ctrl_r[B_SRC1] || ctrl_nxt[B_SRC1]) begin
                        ctrl_nxt[B_OFFSET] = ctrl_r[B_OFFSET]; // RULE9
                    end
                end
                REG_QUAL1: begin
                    merged = merge(DATA_W'(qual_r[0]), wdata_r, wstrb_r);
                    qual_nxt[0] = merged[2*QUAL_W-1:0]; // RULE12
                end
                REG_QUAL2: begin
                    merged = merge(DATA_W'(qual_r[1]), wdata_r, wstrb_r);
                    qual_nxt[1] = merged[2*QUAL_W-1:0]; // RULE10
                end
                REG_RATE: begin
                    merged = merge(DATA_W'(rate_r), wdata_r, wstrb_r);
                    if (merged < DATA_W'(RATE_MIN)) rate_nxt = RATE_MIN;
                    else if (merged > DATA_W'(RATE_MAX)) rate_nxt = RATE_MAX;
                    else rate_nxt = merged[RATE_W-1:0]; // RULE1
                end
                REG_RATIO: begin
                    merged = merge(DATA_W'(ratio_r), wdata_r, wstrb_r);
                    if (merged < DATA_W'(RATIO_MIN)) ratio_nxt = RATIO_MIN;
                    else if (merged > DATA_W'(RATIO_MAX)) ratio_nxt = RATIO_MAX;
                    else ratio_nxt = merged[RATIO_W-1:0];
                end
                default: merged = '0;
            endcase
            refuse_nxt = 1'b0;
        end
        // mixed measurement with ratio above one blocks the source
        if ((ctrl_nxt[B_KIND] ^ ctrl_nxt[B_KIND+1])
            && ratio_nxt > RATIO_MIN && ctrl_nxt[B_SRC1]) begin
            ctrl_nxt[B_SRC1] = 1'b0; // RULE4
            refuse_nxt = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            ctrl_r <= CTRL_RST; // RULE2 RULE6 RULE7 RULE8
            qual_r <= '{QUAL_RST, QUAL_RST};
            rate_r <= RATE_MAX;
            ratio_r <= RATIO_MIN;
            refuse_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            qual_r <= qual_nxt;
            rate_r <= rate_nxt;
            ratio_r <= ratio_nxt;
            refuse_r <= refuse_nxt;
        end
    end

    assign refuse_now = (ctrl_r[B_KIND] ^ ctrl_r[B_KIND+1])
        && ratio_r > RATIO_MIN;
    assign src_act = ctrl_r[B_SRC1] && ctrl_r[B_KIND];
    assign SRC_KIND_DIGITAL = src_act; // RULE3
    assign SAMPLE_RATE_SETTING = rate_r; // RULE1

    // per-channel capture and shaping
    for (genvar i = 0; i < NCH; i++) begin : gch
        logic [WORD_W-1:0] lane_word;
        logic lane_tog, t1_r, t2_r, t3_r, seen_r, seen_nxt, evt;
        logic [WORD_W-1:0] samp_r, samp_nxt;
        logic val_r, val_nxt, digital, from_src, pod_sel;

        assign digital = ctrl_r[B_KIND+i]; // RULE2
        assign from_src = (i == 0) && src_act;
        assign pod_sel = (i == 0) ? 1'b1 : ctrl_r[B_CH2_POD1]; // RULE6 RULE7

        dicr_lane #(.WORD_W(WORD_W), .QUAL_W(QUAL_W)) u_lane (
            .link_clk(LINK_CLK),
            .rst_cd(RESET),
            .enable_cd(digital && !from_src),
            .pod_sel_cd(pod_sel),
            .care_cd(qual_r[i][Q_CARE_LSB +: QUAL_W]),
            .value_cd(qual_r[i][Q_VAL_LSB +: QUAL_W]),
            .pod1(POD1_DATA),
            .pod2(POD2_DATA),
            .qual(QUALIFIER),
            .word(lane_word),
            .toggle(lane_tog)
        );

        always_ff @(posedge CLK) begin
            t1_r <= lane_tog;
            t2_r <= t1_r;
            t3_r <= t2_r;
        end

        assign evt = (t2_r == t3_r) && (t3_r != seen_r);

        always_comb begin
            seen_nxt = evt ? t3_r : seen_r;
            samp_nxt = samp_r;
            val_nxt = 1'b0;
            if (from_src) begin
                if (SRC_VALID) begin
                    samp_nxt = shape(SRC_WORD, SRC_OFFSET_BINARY, 1'b0,
                        SRC_UPPER_ALIGN); // RULE3 RULE5
                    val_nxt = 1'b1;
                end
            end else if (digital && evt) begin
                samp_nxt = shape(lane_word, ctrl_r[B_OFFSET+i],
                    ctrl_r[B_BITS8+i], ctrl_r[B_UPPER+i]); // RULE8 RULE10
                val_nxt = 1'b1;
            end
        end

        always_ff @(posedge CLK) begin
            if (RESET) begin
                seen_r <= 1'b0;
                samp_r <= '0;
                val_r <= 1'b0;
            end else begin
                seen_r <= seen_nxt;
                samp_r <= samp_nxt;
                val_r <= val_nxt;
            end
        end

        assign samp_q[i] = samp_r;
        assign sval_q[i] = val_r;

        chk_valid_kind: assert property (val_r |-> $past(digital)) // RULE2
            else $error("sample taken on an analog channel");
    end

    assign SAMPLE1 = samp_q[0];
    assign SAMPLE2 = samp_q[1];
    assign SAMPLE_VALID = sval_q;

    chk_reset_defaults: assert property ($fell(RESET) |-> // RULE2
        ctrl_r == CTRL_RST && rate_r == RATE_MAX)
        else $error("configuration not at defaults after reset");
    chk_src_refused: assert property (ctrl_r[B_SRC1] |-> !refuse_now) // RULE4
        else $error("source route held while mixed ratio above one");
    chk_src_forces: assert property (ctrl_r[B_SRC1] && ctrl_r[B_KIND] // RULE3
        && SRC_VALID |-> SRC_KIND_DIGITAL ##1 SAMPLE_VALID[0])
        else $error("source kind not forced digital");
    chk_rate_range: assert property (rate_r >= RATE_MIN // RULE1
        && rate_r <= RATE_MAX)
        else $error("sample rate outside range");
    chk_fmt_locked: assert property (ctrl_r[B_SRC1] && $past(ctrl_r[B_SRC1]) // RULE9
        |-> $stable(ctrl_r[B_OFFSET]))
        else $error("channel 1 format changed while on source");
    chk_src_word: assert property (src_act && SRC_VALID && // RULE5
        !SRC_UPPER_ALIGN && !SRC_OFFSET_BINARY
        |=> SAMPLE1[KEEP_W-1:0] == $past(SRC_WORD[KEEP_W-1:0])
        && SAMPLE_VALID[0])
        else $error("source word not taken by channel 1");
    chk_offset_invert: assert property (SAMPLE_VALID[1] // RULE13
        && $past(ctrl_r[B_OFFSET+1] && ctrl_r[B_BITS8+1])
        |-> SAMPLE2[BYTE_W-1] == ~$past(gch[1].lane_word[BYTE_W-1]))
        else $error("offset binary top bit not inverted");
    chk_lower_keep: assert property (SAMPLE_VALID[1] && $past( // RULE11
        !ctrl_r[B_OFFSET+1] && !ctrl_r[B_BITS8+1] && !ctrl_r[B_UPPER+1])
        |-> SAMPLE2 == {{CUT_W{$past(gch[1].lane_word[KEEP_W-1])}},
        $past(gch[1].lane_word[KEEP_W-1:0])})
        else $error("lower 13 bits not kept");
    chk_write_resp: assert property (wr_en |=> S_AXI_BVALID
        && !aw_full_r && !w_full_r)
        else $error("write response missing");
endmodule
`default_nettype wire

// ---- sim/dicr_pod_model.sv ----
// external system model: data clock, pod words and qualifier lines
`timescale 1ns/10ps
`default_nettype none
module dicr_pod_model (
    output var logic link_clk,
    output var logic [15:0] pod1,
    output var logic [15:0] pod2,
    output var logic [7:0] qual
);
    initial begin
        link_clk = 1'h0;
        pod1 = 16'h0000;
        pod2 = 16'hFFFF;
        qual = 8'h00;
    end
    // one data-clock pulse, clock idle outside the frame
    task automatic frame(input logic [15:0] p1, input logic [15:0] p2,
            input logic [7:0] q);
        #1.3;
        pod1 = p1;
        pod2 = p2;
        qual = q;
        #1.5 link_clk = 1'h1;
        #3 link_clk = 1'h0;
        #0.2;
        pod1 = ~p1;
        pod2 = ~p2;
        qual = ~q;
    endtask
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
// self-checking bench for the two-channel input router
`timescale 1ns/10ps
`default_nettype none
module tb;
    import dicr_pkg::*;
    logic clk = 1'h0, rst = 1'h1, link;
    logic [4:0] awaddr = 5'h00, araddr = 5'h00;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [15:0] src_word = 16'h0000, s1, s2, p1, p2, r1, r2;
    logic src_valid = 1'h0, src_up = 1'h0, src_off = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, src_kind;
    logic [1:0] bresp, rresp, svalid;
    logic [7:0] qual, qc1 = 8'h00, qv1 = 8'h00, qc2 = 8'h00, qv2 = 8'h00;
    logic [27:0] rate;
    logic [9:0] cfg = 10'h300;
    logic loose = 1'h0;
    int bad_count = 0, check_count = 0, cyc = 0, seed = 9, i, m;
    logic [15:0] q1[$], q2[$];
    logic [33:0] rq[$], bq[$];

    always #10 clk = ~clk;

    dicr_top i_dicr_top (.CLK(clk), .RESET(rst),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .LINK_CLK(link),
        .POD1_DATA(p1), .POD2_DATA(p2), .QUALIFIER(qual),
        .SRC_WORD(src_word), .SRC_VALID(src_valid),
        .SRC_UPPER_ALIGN(src_up), .SRC_OFFSET_BINARY(src_off),
        .SRC_KIND_DIGITAL(src_kind), .SAMPLE1(s1), .SAMPLE2(s2),
        .SAMPLE_VALID(svalid), .SAMPLE_RATE_SETTING(rate));
    dicr_pod_model i_pod (.link_clk(link), .pod1(p1), .pod2(p2),
        .qual(qual));

    function automatic logic [15:0] shape(input logic [15:0] w,
            input logic off, input logic b8, input logic up);
        logic [15:0] x;
        logic signed [16:0] t;
        x = w ^ {off, 15'h0000};
        if (b8) begin
            x = {8'h00, w[7:0] ^ {off, 7'h00}};
            return {{8{x[7]}}, x[7:0]};
        end
        if (!up) begin
            x = {3'h0, w[12:0] ^ {off, 12'h000}};
            return {{3{x[12]}}, x[12:0]};
        end
        t = ($signed({x[15], x}) + 17'sh0_0004) >>> 3;
        if (t > 17'sh0_0FFF) t = 17'sh0_0FFF;
        return {{3{t[12]}}, t[12:0]};
    endfunction

    task automatic cmp_word(input logic [15:0] got, input logic [15:0] e);
        check_count++;
        if (got !== e) begin
            bad_count++;
            $display("unexpected sample at %0t: %h not %h", $time, got, e);
        end
    endtask
    task automatic cmp_bus(input logic [33:0] got, input logic [33:0] e);
        check_count++;
        if (got !== e) begin
            bad_count++;
            $display("unexpected value at %0t: %h not %h", $time, got, e);
        end
    endtask
    task automatic results;
        $display("checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (bvalid && bready) cmp_bus({bresp, 32'h0000_0000}, bq.pop_front());
        if (rvalid && rready) cmp_bus({rresp, rdata}, rq.pop_front());
        if (!rst && svalid[0] && q1.size() > 0) cmp_word(s1, q1.pop_front());
        else if (!rst && svalid[0] && !loose) cmp_word(s1, ~s1);
        if (!rst && svalid[1] && q2.size() > 0) cmp_word(s2, q2.pop_front());
        else if (!rst && svalid[1] && !loose) cmp_word(s2, ~s2);
        if (cyc == 5000) begin
            bad_count++;
            results;
        end
    end

    task automatic wr(input logic [4:0] a, input logic [31:0] d,
            input logic [1:0] r);
        logic aw, w;
        aw = 1'h0;
        w = 1'h0;
        bq.push_back({r, 32'h0000_0000});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        while (!(aw && w)) begin
            @(posedge clk);
            if (!aw && awready) aw = 1'h1;
            if (aw) awvalid <= 1'h0;
            if (!w && wready) w = 1'h1;
            if (w) wvalid <= 1'h0;
        end
        bready <= 1'h1;
        do @(posedge clk); while (!bvalid);
        bready <= 1'h0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] d);
        rq.push_back({RESP_OKAY, d});
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'h0;
        do @(posedge clk); while (!rvalid);
        rready <= 1'h0;
    endtask
    task automatic setcfg(input logic [9:0] c);
        cfg = c;
        wr(REG_CTRL, {22'h00_0000, c}, RESP_OKAY);
        loose = 1'h1;
        repeat (3) i_pod.frame(16'($random(seed)), 16'h0000, 8'h00);
        repeat (12) @(posedge clk);
        loose = 1'h0;
    endtask
    task automatic cap(input logic [7:0] q);
        r1 = 16'($random(seed));
        r2 = 16'($random(seed));
        if (cfg[0] && !cfg[2] && ((q ^ qv1) & qc1) == 8'h00)
            q1.push_back(shape(r1, cfg[4], cfg[6], cfg[8]));
        if (cfg[1] && ((q ^ qv2) & qc2) == 8'h00)
            q2.push_back(shape(cfg[3] ? r1 : r2, cfg[5], cfg[7], cfg[9]));
        i_pod.frame(r1, r2, q);
        repeat (10) @(posedge clk);
    endtask
    task automatic srcw;
        logic [15:0] w;
        logic u, o;
        w = 16'($random(seed));
        u = 1'($random(seed));
        o = 1'($random(seed));
        q1.push_back(shape(w, o, 1'h0, u));
        src_word <= w;
        src_up <= u;
        src_off <= o;
        src_valid <= 1'h1;
        @(posedge clk);
        src_valid <= 1'h0;
        repeat (3) @(posedge clk);
    endtask

    initial begin
        repeat (4) i_pod.frame(16'h0000, 16'h0000, 8'h00);
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        rd(REG_CTRL, 32'h0000_0300);
        rd(REG_RATE, 32'h0F42_4000);
        rd(REG_RATIO, 32'h0000_0001);
        rd(REG_STATUS, 32'h0000_0000);
        cmp_bus({33'h0_0000_0000, src_kind}, 34'h0_0000_0000);
        wr(REG_RATE, 32'h0000_0000, RESP_OKAY);
        rd(REG_RATE, 32'h0000_0001);
        wr(REG_RATE, 32'hFFFF_FFFF, RESP_OKAY);
        rd(REG_RATE, 32'h0F42_4000);
        cmp_bus({6'h00, rate}, {6'h00, RATE_MAX});
        wr(REG_STATUS, 32'h0000_000F, RESP_SLVERR);
        wr(5'h02, 32'h0000_0001, RESP_SLVERR);
        rd(REG_STATUS, 32'h0000_0000);
        for (m = 0; m < 8; m++) begin
            setcfg({{2{m[2]}}, {2{m[1]}}, {2{m[0]}}, m[0], 1'h0, 2'h3});
            repeat (2) cap(8'h00);
        end
        qc1 = 8'hFF;
        qv1 = 8'hA5;
        wr(REG_QUAL1, 32'h0000_A5FF, RESP_OKAY);
        setcfg(10'h003);
        cap(8'hA5);
        cap(8'h5A);
        cap(8'hA4);
        setcfg(10'h001);
        wr(REG_RATIO, 32'h0000_03E8, RESP_OKAY);
        rd(REG_RATIO, 32'h0000_0200);
        wr(REG_CTRL, 32'h0000_0005, RESP_OKAY);
        rd(REG_CTRL, 32'h0000_0001);
        rd(REG_STATUS, 32'h0000_0009);
        cmp_bus({33'h0_0000_0000, src_kind}, 34'h0_0000_0000);
        wr(REG_RATIO, 32'h0000_0001, RESP_OKAY);
        setcfg(10'h005);
        rd(REG_STATUS, 32'h0000_0005);
        cmp_bus({33'h0_0000_0000, src_kind}, 34'h0_0000_0001);
        for (i = 0; i < 6; i++) srcw;
        cap(8'h00);
        wr(REG_CTRL, 32'h0000_0015, RESP_OKAY);
        rd(REG_CTRL, 32'h0000_0005);
        repeat (20) @(posedge clk);
        cmp_bus({2'h0, 32'(q1.size() + q2.size())}, 34'h0_0000_0000);
        results;
    end
endmodule
`default_nettype wire
